//--- core/dpspi_top.sv
// Serial programming, divider latches and lock detect of a dual synthesizer.
// Assumes the controller stops the serial clock while the load strobe is high.
//
// Behaviour
// RL1 - Each rising serial clock shifts one data bit into the 23-bit register
// RL2 - Load strobe rise copies the word into the latch named by its control bits
// RL3 - Four latches: IF reference, IF programmable, RF reference, RF programmable
// RL4 - Reference dividers are 14-bit, ratio 3 to 16383
// RL5 - Swallow counter is 7-bit, values 0 to 127
// RL6 - Programmable counter is 11-bit, values 3 to 2047
// RL7 - Word picks prescaler: RF 64/65 or 128/129, IF 32/33 or 64/65
// RL8 - Word picks charge pump current, 1.5 mA or 6.0 mA
// RL9 - Status pin shows monitor when select bit high, lock when low
// RL10 - Each section runs while its power input high, saves power when low
// RL11 - Controller holds power inputs low at power-up, never floating
// RL12 - Digital lock detector drives the lock indicator
// RL13 - Field placement and shift order are constants of the package
// RL14 - Total ratio is low modulus times program count plus swallow count
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module dpspi_top
  import dpspi_pkg::*;
(
  input  wire logic         CLOCK,
  input  wire logic         RSTN,
  input  wire logic         CLK_EN,
  input  wire logic         PSEL,
  input  wire logic         PENABLE,
  input  wire logic         PWRITE,
  input  wire logic [11:0]  PADDR,
  input  wire logic [31:0]  PWDATA,
  output logic      [31:0]  PRDATA,
  output logic              PREADY,
  output logic              PSLVERR,
  input  wire logic         SER_CLK,
  input  wire logic         SER_DATA,
  input  wire logic         LOAD_STROBE,
  input  wire logic         IF_SECTION_POWER_N,
  input  wire logic         RF_SECTION_POWER_N,
  input  wire logic         REFERENCE_OSC_INPUT,
  input  wire logic         IF_PHASE_ERR,
  input  wire logic         RF_PHASE_ERR,
  output logic              STATUS_OUT,
  output logic              LOCK_INDICATOR,
  output logic      [13:0]  IF_REF_DIV,
  output logic      [13:0]  RF_REF_DIV,
  output logic      [6:0]   IF_SWALLOW,
  output logic      [6:0]   RF_SWALLOW,
  output logic      [10:0]  IF_PROG,
  output logic      [10:0]  RF_PROG,
  output logic              IF_PSC_HIGH,
  output logic              RF_PSC_HIGH,
  output logic              IF_CP_HIGH,
  output logic              RF_CP_HIGH,
  output logic              IF_ACTIVE,
  output logic              RF_ACTIVE
);

////////////////////////////////////////////////////////////////////////////////
// State
  typedef struct packed {
    logic [2:0]               strobe_sync;
    logic [2:0]               osc_sync;
    logic [1:0][2:0]          pwr_sync;
    logic [1:0][2:0]          err_sync;
    logic                     strobe_lvl;
    logic                     osc_lvl;
    logic [1:0]               pwr_lvl;
    logic [1:0]               err_lvl;
    logic [1:0][13:0]         ref_div;
    logic [1:0]               cp_high;
    logic                     stat_sel;
    logic [1:0][6:0]          swallow;
    logic [1:0][10:0]         prog;
    logic [1:0]               psc_high;
    logic [1:0][13:0]         rcnt;
    logic [1:0]               mon;
    logic [1:0][7:0]          lock_cnt;
    logic [1:0]               locked;
    logic [1:0][RATIO_W-1:0]  ratio;
    logic                     status_out;
    logic                     lock_ind;
    logic                     ctrl_en;
    logic [7:0]               rej_cnt;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
  } dpspi_state_s;
  typedef struct packed {
    logic [WORD_W-1:0] shreg;
  } dpspi_link_s;
  dpspi_state_s       st_ff;
  dpspi_state_s       nxt_st;
  dpspi_link_s        lk_ff;
  dpspi_link_s        nxt_lk;
  logic [1:0]         rst_sync_ff;
  logic               rst_n;
  logic               strobe_rise;
  logic [WORD_W-1:0]  word;
  assign rst_n = rst_sync_ff[1];
  assign word  = lk_ff.shreg;

////////////////////////////////////////////////////////////////////////////////
// Reset release
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

////////////////////////////////////////////////////////////////////////////////
// Link domain: shift register, MSB first, new bit enters at bit 0
  always_comb
  begin
    nxt_lk       = lk_ff;
    nxt_lk.shreg = {lk_ff.shreg[WORD_W-2:0], SER_DATA}; // [RL1] [RL13]
  end
  always_ff @(posedge SER_CLK or negedge rst_n)
  begin
    if (!rst_n)
      lk_ff <= '0;
    else
      lk_ff <= nxt_lk;
  end

////////////////////////////////////////////////////////////////////////////////
// System domain
  always_comb
  begin
    logic [7:0]         mod_lo;
    logic               osc_rise;
    logic [RATIO_W-1:0] prod;
    mod_lo      = 8'h00;
    osc_rise    = 1'b0;
    prod        = '0;
    nxt_st      = st_ff;
    strobe_rise = 1'b0;
    // Pins: a change counts once the second and third stages agree
    nxt_st.strobe_sync = {st_ff.strobe_sync[1:0], LOAD_STROBE};
    nxt_st.osc_sync    = {st_ff.osc_sync[1:0], REFERENCE_OSC_INPUT};
    nxt_st.pwr_sync[0] = {st_ff.pwr_sync[0][1:0], IF_SECTION_POWER_N};
    nxt_st.pwr_sync[1] = {st_ff.pwr_sync[1][1:0], RF_SECTION_POWER_N};
    nxt_st.err_sync[0] = {st_ff.err_sync[0][1:0], IF_PHASE_ERR};
    nxt_st.err_sync[1] = {st_ff.err_sync[1][1:0], RF_PHASE_ERR};
    if (st_ff.strobe_sync[2] == st_ff.strobe_sync[1])
    begin
      nxt_st.strobe_lvl = st_ff.strobe_sync[2];
      strobe_rise       = st_ff.strobe_sync[2] && !st_ff.strobe_lvl;
    end
    if (st_ff.osc_sync[2] == st_ff.osc_sync[1])
    begin
      nxt_st.osc_lvl = st_ff.osc_sync[2];
      osc_rise       = st_ff.osc_sync[2] && !st_ff.osc_lvl;
    end
    for (int s = 0; s < 2; s++)
    begin
      if (st_ff.pwr_sync[s][2] == st_ff.pwr_sync[s][1])
        nxt_st.pwr_lvl[s] = st_ff.pwr_sync[s][2];
      if (st_ff.err_sync[s][2] == st_ff.err_sync[s][1])
        nxt_st.err_lvl[s] = st_ff.err_sync[s][2];
    end
    // Serial word is quiet while the strobe is high, so it is sampled here
    if (strobe_rise && st_ff.ctrl_en)
    begin
      case (word[CTRL_LSB +: 2]) // [RL2] [RL3]
        DST_IF_REF, DST_RF_REF:
        begin
          if (word[R_LSB +: R_W] >= R_MIN) // [RL4]
          begin
            nxt_st.ref_div[word[CTRL_LSB+1]] = word[R_LSB +: R_W];
            nxt_st.cp_high[word[CTRL_LSB+1]] = word[CP_BIT]; // [RL8]
            if (word[CTRL_LSB+1])
              nxt_st.stat_sel = word[STAT_SEL_BIT];
          end
          else
            nxt_st.rej_cnt = st_ff.rej_cnt + 8'h01;
        end
        DST_IF_PROG, DST_RF_PROG:
        begin
          // Swallow count above program count cannot be realised
          if (word[N_LSB +: N_W] >= N_MIN && // [RL6]
              11'(word[A_LSB +: A_W]) <= word[N_LSB +: N_W]) // [RL14]
          begin
            nxt_st.swallow[word[CTRL_LSB+1]]  = word[A_LSB +: A_W]; // [RL5]
            nxt_st.prog[word[CTRL_LSB+1]]     = word[N_LSB +: N_W];
            nxt_st.psc_high[word[CTRL_LSB+1]] = word[PSC_BIT]; // [RL7]
          end
          else
            nxt_st.rej_cnt = st_ff.rej_cnt + 8'h01;
        end
        default: nxt_st.rej_cnt = st_ff.rej_cnt;
      endcase
    end
    // Per section: reference divider, lock detector, total ratio
    for (int s = 0; s < 2; s++)
    begin
      mod_lo = (s == 0) ? IF_MOD_LO : RF_MOD_LO;
      if (st_ff.psc_high[s])
        mod_lo = {mod_lo[6:0], 1'b0}; // [RL7]
      prod = RATIO_W'(mod_lo) * RATIO_W'(st_ff.prog[s]);
      nxt_st.ratio[s] = prod + RATIO_W'(st_ff.swallow[s]); // [RL14]
      if (!st_ff.pwr_lvl[s]) // [RL10]
      begin
        nxt_st.rcnt[s]     = 14'h0000;
        nxt_st.mon[s]      = 1'b0;
        nxt_st.lock_cnt[s] = 8'h00;
        nxt_st.locked[s]   = 1'b0;
      end
      else
      begin
        if (osc_rise)
        begin
          if (st_ff.rcnt[s] >= st_ff.ref_div[s] - 14'h0001) // [RL4]
          begin
            nxt_st.rcnt[s] = 14'h0000;
            nxt_st.mon[s]  = !st_ff.mon[s];
          end
          else
            nxt_st.rcnt[s] = st_ff.rcnt[s] + 14'h0001;
        end
        if (st_ff.err_lvl[s]) // [RL12]
        begin
          nxt_st.lock_cnt[s] = 8'h00;
          nxt_st.locked[s]   = 1'b0;
        end
        else if (st_ff.lock_cnt[s] == LOCK_CNT_MAX)
          nxt_st.locked[s] = 1'b1;
        else
          nxt_st.lock_cnt[s] = st_ff.lock_cnt[s] + 8'h01;
      end
    end
    // A sleeping section does not hold the indicator low while the other section is awake
    nxt_st.lock_ind = (st_ff.locked[0] || !st_ff.pwr_lvl[0]) &&
                      (st_ff.locked[1] || !st_ff.pwr_lvl[1]) &&
                      (st_ff.pwr_lvl[0] || st_ff.pwr_lvl[1]); // [RL12]
    nxt_st.status_out = st_ff.stat_sel ? st_ff.mon[1] : st_ff.lock_ind; // [RL9]
    // APB slave: answers on the second access cycle
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    if (PSEL && PENABLE && !st_ff.pready)
    begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = 32'h0000_0000;
      case (PADDR)
        OFS_CTRL:
        begin
          if (PWRITE)
            nxt_st.ctrl_en = PWDATA[0];
          else
            nxt_st.prdata = {31'h0, st_ff.ctrl_en};
        end
        OFS_STATUS:  nxt_st.prdata = {20'h0, st_ff.rej_cnt, st_ff.pwr_lvl, st_ff.locked};
        OFS_IF_REF:  nxt_st.prdata = {14'h0, st_ff.cp_high[0], 3'h0, st_ff.ref_div[0]};
        OFS_RF_REF:  nxt_st.prdata = {14'h0, st_ff.stat_sel, st_ff.cp_high[1], 2'h0,
                                      st_ff.ref_div[1]};
        OFS_IF_PROG: nxt_st.prdata = {11'h0, st_ff.psc_high[0], 1'b0, st_ff.prog[0],
                                      1'b0, st_ff.swallow[0]};
        OFS_RF_PROG: nxt_st.prdata = {11'h0, st_ff.psc_high[1], 1'b0, st_ff.prog[1],
                                      1'b0, st_ff.swallow[1]};
        OFS_IF_RAT:  nxt_st.prdata = {14'h0, st_ff.ratio[0]};
        OFS_RF_RAT:  nxt_st.prdata = {14'h0, st_ff.ratio[1]};
        default:     nxt_st.pslverr = 1'b1;
      endcase
    end
  end
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff         <= '0;
      st_ff.ref_div <= {R_RST, R_RST};
      st_ff.prog    <= {N_RST, N_RST};
      st_ff.swallow <= {A_RST, A_RST};
      st_ff.ctrl_en <= CTRL_EN_RST;
    end
    else if (CLK_EN)
      st_ff <= nxt_st;
  end
  assign PRDATA         = st_ff.prdata;
  assign PREADY         = st_ff.pready;
  assign PSLVERR        = st_ff.pslverr;
  assign STATUS_OUT     = st_ff.status_out;
  assign LOCK_INDICATOR = st_ff.lock_ind;
  assign IF_REF_DIV     = st_ff.ref_div[0];
  assign RF_REF_DIV     = st_ff.ref_div[1];
  assign IF_SWALLOW     = st_ff.swallow[0];
  assign RF_SWALLOW     = st_ff.swallow[1];
  assign IF_PROG        = st_ff.prog[0];
  assign RF_PROG        = st_ff.prog[1];
  assign IF_PSC_HIGH    = st_ff.psc_high[0];
  assign RF_PSC_HIGH    = st_ff.psc_high[1];
  assign IF_CP_HIGH     = st_ff.cp_high[0];
  assign RF_CP_HIGH     = st_ff.cp_high[1];
  assign IF_ACTIVE      = st_ff.pwr_lvl[0];
  assign RF_ACTIVE      = st_ff.pwr_lvl[1];

////////////////////////////////////////////////////////////////////////////////
// Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);
  a_shift_in: assert property (@(posedge SER_CLK) disable iff (!rst_n) // [RL1]
    1'b1 |=> lk_ff.shreg[0] == $past(SER_DATA))
    else $error("serial bit not shifted in");
  a_rf_ref_load: assert property ( // [RL2]
    (CLK_EN && strobe_rise && st_ff.ctrl_en && word[1:0] == DST_RF_REF &&
     word[R_LSB +: R_W] >= R_MIN) |=> RF_REF_DIV == $past(word[R_LSB +: R_W]))
    else $error("RF reference latch not loaded");
  a_ref_min: assert property (st_ff.ref_div[0] >= R_MIN && st_ff.ref_div[1] >= R_MIN) // [RL4]
    else $error("reference ratio below minimum");
  a_swallow_limit: assert property ( // [RL14]
    (CLK_EN && strobe_rise && st_ff.ctrl_en && word[1:0] == DST_RF_PROG) |=>
    RF_SWALLOW <= RF_PROG[6:0] || RF_PROG > 11'h07F)
    else $error("swallow count above program count");
  a_status_mux: assert property ( // [RL9]
    (CLK_EN && st_ff.stat_sel) |=> STATUS_OUT == $past(st_ff.mon[1]))
    else $error("status pin not showing monitor");
  a_power_save: assert property ( // [RL10]
    (CLK_EN && !st_ff.pwr_lvl[1]) |=> !st_ff.locked[1] && st_ff.rcnt[1] == 14'h0000)
    else $error("sleeping section still running");
  a_lock_drop: assert property ( // [RL12]
    (CLK_EN && st_ff.err_lvl[1]) |=> !st_ff.locked[1])
    else $error("lock kept despite phase error");
  a_ratio_calc: assert property ( // [RL14]
    (CLK_EN && $stable(st_ff.prog[1]) && !st_ff.psc_high[1]) |=>
    st_ff.ratio[1] == RATIO_W'(RF_MOD_LO) * RATIO_W'($past(st_ff.prog[1]))
                      + RATIO_W'($past(st_ff.swallow[1])))
    else $error("RF total ratio wrong");
  c_load_word:  cover property (strobe_rise && st_ff.ctrl_en);
  c_locked:     cover property (st_ff.lock_ind);
  c_apb_err:    cover property (st_ff.pslverr);
endmodule : dpspi_top
`default_nettype wire

//--- core/dpspi_pkg.sv
// Constants for the dual synthesizer serial programming block.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package dpspi_pkg;
  // Serial word layout, control bits shifted in last
  localparam int          WORD_W    = 23;
  localparam int          CTRL_LSB  = 0;
  localparam int          R_LSB     = 2;
  localparam int          R_W       = 14;
  localparam int          CP_BIT    = 16;
  localparam int          STAT_SEL_BIT = 17;
  localparam int          A_LSB     = 2;
  localparam int          A_W       = 7;
  localparam int          N_LSB     = 9;
  localparam int          N_W       = 11;
  localparam int          PSC_BIT   = 20;
  localparam int          RATIO_W   = 18;
  localparam logic [1:0]  DST_IF_REF  = 2'h0;
  localparam logic [1:0]  DST_IF_PROG = 2'h1;
  localparam logic [1:0]  DST_RF_REF  = 2'h2;
  localparam logic [1:0]  DST_RF_PROG = 2'h3;
  // Legal ranges and reset values
  localparam logic [13:0] R_MIN     = 14'h0003;
  localparam logic [10:0] N_MIN     = 11'h003;
  localparam logic [13:0] R_RST     = 14'h3FFF;
  localparam logic [10:0] N_RST     = 11'h7FF;
  localparam logic [6:0]  A_RST     = 7'h00;
  // Lower prescaler moduli; the high setting doubles them
  localparam logic [7:0]  IF_MOD_LO = 8'h20;
  localparam logic [7:0]  RF_MOD_LO = 8'h40;
  // Lock detector quiet time
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          LOCK_TIME_NS  = 1000;
  localparam int          LOCK_CYCLES   = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  LOCK_CNT_MAX  = 8'(LOCK_CYCLES);
  // APB map
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_STATUS  = 12'h004;
  localparam logic [11:0] OFS_IF_REF  = 12'h008;
  localparam logic [11:0] OFS_IF_PROG = 12'h00C;
  localparam logic [11:0] OFS_RF_REF  = 12'h010;
  localparam logic [11:0] OFS_RF_PROG = 12'h014;
  localparam logic [11:0] OFS_IF_RAT  = 12'h018;
  localparam logic [11:0] OFS_RF_RAT  = 12'h01C;
  localparam logic        CTRL_EN_RST = 1'b1;
endpackage : dpspi_pkg

//--- verif/dpspi_host.sv
// Host controller model for the three-wire programming link.
// Assumes the caller leaves the strobe low between frames.
`timescale 1ns/100ps
`default_nettype none
module dpspi_host (
  output var logic ser_clk,
  output var logic ser_data,
  output var logic load_strobe,
  output var logic if_pwr_n,
  output var logic rf_pwr_n
);
  initial
  begin
    ser_clk     = 1'b0;
    ser_data    = 1'b0;
    load_strobe = 1'b0;
    if_pwr_n    = 1'b0;  // Held low while supply comes up, never floating
    rf_pwr_n    = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [22:0] w);
    #3;
    for (int i = 22; i >= 0; i--)
    begin
      ser_data = w[i];  // Control bits go last
      #16 ser_clk = 1'b1;  // Bit set up half a period before the rising edge
      #16 ser_clk = 1'b0;
    end
    ser_data    = ~w[0];  // Released line must not look like a held bit
    load_strobe = 1'b1;  // Clock stays still while the strobe is high
    #100 load_strobe = 1'b0;
    #100;
  endtask : send
  task automatic set_power(input logic i, input logic r);
    if_pwr_n <= i;
    rf_pwr_n <= r;
  endtask : set_power
endmodule : dpspi_host
`default_nettype wire

//--- verif/dpspi_top_tb.sv
// Self-checking bench for the dual synthesizer programming block.
// Assumes the host model drives the link; APB and phase inputs come from here.
`timescale 1ns/100ps
`default_nettype none
module dpspi_top_tb
  import dpspi_pkg::*;
;
  logic        clock = 1'b0, rstn = 1'b0, ref_osc = 1'b0, if_err = 1'b1, rf_err = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr, clk_en = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        ser_clk, ser_data, load_strobe, if_pwr_n, rf_pwr_n, status_out, lock_ind;
  logic [13:0] if_r, rf_r;
  logic [6:0]  if_a, rf_a;
  logic [10:0] if_n, rf_n;
  logic        if_psc, rf_psc, if_cp, rf_cp, if_act, rf_act;
  int          error_cnt = 0, num_checks = 0;
  always #5 clock = ~clock;
  always #40 ref_osc = ~ref_osc;  // Slow enough for the synchronizer
  dpspi_host host (.ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe),
    .if_pwr_n(if_pwr_n), .rf_pwr_n(rf_pwr_n));
  dpspi_top DUT (.CLOCK(clock), .RSTN(rstn), .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SER_CLK(ser_clk), .SER_DATA(ser_data), .LOAD_STROBE(load_strobe),
    .IF_SECTION_POWER_N(if_pwr_n), .RF_SECTION_POWER_N(rf_pwr_n),
    .REFERENCE_OSC_INPUT(ref_osc), .IF_PHASE_ERR(if_err), .RF_PHASE_ERR(rf_err),
    .STATUS_OUT(status_out), .LOCK_INDICATOR(lock_ind), .IF_REF_DIV(if_r), .RF_REF_DIV(rf_r),
    .IF_SWALLOW(if_a), .RF_SWALLOW(rf_a), .IF_PROG(if_n), .RF_PROG(rf_n),
    .IF_PSC_HIGH(if_psc), .RF_PSC_HIGH(rf_psc), .IF_CP_HIGH(if_cp), .RF_CP_HIGH(rf_cp),
    .IF_ACTIVE(if_act), .RF_ACTIVE(rf_act));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Setup, then access held until pready is sampled high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hung wait
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [22:0] ref_w(logic [1:0] d, logic [13:0] r, logic cp, logic sel);
    ref_w = {5'h00, sel, cp, r, d};
  endfunction : ref_w
  function automatic logic [22:0] prog_w(logic [1:0] d, logic [6:0] a, logic [10:0] n,
                                          logic psc);
    prog_w = {2'h0, psc, n, a, d};
  endfunction : prog_w
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(if_r, 32'h3FFF);
    chk(rf_n, 32'h7FF);
    chk(rf_a, 32'h0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rdat, 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    chk({rerr, rdat[30:0]}, 32'h80000000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_ref;
    host.send(ref_w(DST_IF_REF, 14'h0003, 1'b1, 1'b0));
    chk({if_cp, if_r}, 32'h4003);  // Lowest ratio, high pump
    chk(rf_r, 32'h3FFF);
    host.send(ref_w(DST_RF_REF, 14'h1234, 1'b0, 1'b0));
    chk({rf_cp, rf_r, if_r}, {4'h0, 14'h1234, 14'h0003});
    apb(1'b0, OFS_RF_REF, 32'h0);
    chk(rdat[13:0], 32'h1234);
    $display("test reference done");
  endtask : t_ref
  task automatic t_prog;
    host.send(prog_w(DST_IF_PROG, 7'h7F, 11'h7FE, 1'b1));
    chk({if_psc, if_n, if_a}, {13'h0, 1'b1, 11'h7FE, 7'h7F});
    apb(1'b0, OFS_IF_PROG, 32'h0);
    chk(rdat, 32'h0017FE7F);
    apb(1'b0, OFS_IF_RAT, 32'h0);
    chk(rdat, 32'h1FFFF);  // 64 x 2046 + 127
    host.send(prog_w(DST_IF_PROG, 7'h05, 11'h00A, 1'b0));
    apb(1'b0, OFS_IF_RAT, 32'h0);
    chk({if_psc, rdat[30:0]}, 32'h145);  // 32 x 10 + 5
    host.send(prog_w(DST_RF_PROG, 7'h03, 11'h003, 1'b0));
    apb(1'b0, OFS_RF_RAT, 32'h0);
    chk({rf_psc, rf_n, rf_a, rdat[12:0]}, {1'b0, 11'h003, 7'h03, 13'h0C3});
    host.send(prog_w(DST_RF_PROG, 7'h00, 11'h003, 1'b1));
    apb(1'b0, OFS_RF_RAT, 32'h0);
    chk({rf_psc, rdat[30:0]}, 32'h80000180);  // 128 x 3
    $display("test programmable done");
  endtask : t_prog
  task automatic t_reject;
    host.send(ref_w(DST_IF_REF, 14'h0002, 1'b0, 1'b0));
    chk(if_r, 32'h3);  // Ratio below 3 is refused
    host.send(prog_w(DST_RF_PROG, 7'h04, 11'h003, 1'b0));
    chk({rf_a, rf_n}, {7'h00, 11'h003});  // Swallow above program count
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdat[11:4], 32'h2);
    apb(1'b1, OFS_CTRL, 32'h0);
    host.send(ref_w(DST_IF_REF, 14'h0064, 1'b0, 1'b0));
    chk(if_r, 32'h3);  // Loads disabled
    apb(1'b1, OFS_CTRL, 32'h1);
    $display("test reject done");
  endtask : t_reject
  task automatic t_lock;
    int tog;
    logic last;
    tog = 0;
    if_err <= 1'b0;
    rf_err <= 1'b0;
    host.set_power(1'b1, 1'b1);
    cyc(10);
    chk({if_act, rf_act, lock_ind}, 32'h6);  // Sections awake, not yet quiet long
    cyc(110);
    chk({lock_ind, status_out}, 32'h3);  // Select low shows lock
    rf_err <= 1'b1;
    cyc(8);
    chk({lock_ind, status_out}, 32'h0);
    host.set_power(1'b0, 1'b1);
    cyc(8);
    chk({if_act, rf_act}, 32'h1);  // Sections switch independently
    host.send(ref_w(DST_RF_REF, 14'h0004, 1'b0, 1'b1));
    last = status_out;
    repeat (200)
    begin
      @(posedge clock);
      if (status_out !== last)
        tog++;
      last = status_out;
    end
    chk(32'(tog > 2), 32'h1);  // Monitor toggles when selected
    // Clock enable low must freeze the monitor output as well
    clk_en <= 1'b0;
    cyc(1);
    last = status_out;
    tog  = 0;
    repeat (100)
    begin
      @(posedge clock);
      if (status_out !== last)
        tog++;
    end
    chk(tog, 32'h0);
    clk_en <= 1'b1;
    $display("test lock done");
  endtask : t_lock
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial
  begin
    #200000;
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    summarize();
  end
  initial
  begin
    cyc(20);
    rstn <= 1'b1;
    cyc(3);
    t_reset();
    t_ref();
    t_prog();
    t_reject();
    t_lock();
    summarize();
  end
endmodule : dpspi_top_tb
`default_nettype wire
